//--- hdl/rectifier_consts.svh
// Operation
// - Run state word at 0x0030 reads 0 when stopped, 1 when running.
// - Primary alarm bits 0-3: line failure, DC low, DC high, current limit.
// - Primary alarm bits 4-7: battery too low, low, high, overtemperature.
// - Primary 8-15: earth, memory, fan, breaker, fuse, door, block, probe.
// - Regime at 0x0032: 0 auto, 1 float, 2 equalize, 3 boost, 4 test.
// - Rated input: bits 0-14 nominal volts, bit 15 set for three-phase.
// - Relay words 0x0038-0x003B read 1 energised, 0 de-energised in alarm.
// - Secondary bits 0-3: float, equalize, boost charging, boost expired.
// - Secondary 4-7: emergency stop, parallel, pre-alarm, 12-pulse failure.
// - Secondary bit 8 test failed, bit 9 bad phase order on 12-pulse.
// - Battery volts 0x0025, amps 0x0026 in tenths; degrees at 0x0027.
// - Line frequency at 0x0028 as unsigned tenths of a hertz.
// - Phase two, three volts 0x0023-24; line-to-line volts 0x002A-2C.
// - Phase one to three RMS currents at 0x002D, 0x002E, 0x002F.
// - Rated output volts at 0x0033, rated output amps at 0x0034.
// - Read-only firmware words: main processor 0x0036, auxiliary 0x0037.
// - A Modbus master reads the bank; addresses stay backward compatible.
// - Phase one phase-to-neutral volts at 0x0022.
`ifndef RECTIFIER_CONSTS_SVH
`define RECTIFIER_CONSTS_SVH

`define ADDR_PHASE1_VOLT    16'h0022
`define ADDR_PHASE2_VOLT    16'h0023
`define ADDR_PHASE3_VOLT    16'h0024
`define ADDR_BATT_VOLT      16'h0025
`define ADDR_BATT_CURR      16'h0026
`define ADDR_BATT_TEMP      16'h0027
`define ADDR_LINE_FREQ      16'h0028
`define ADDR_LINE12_VOLT    16'h002a
`define ADDR_LINE23_VOLT    16'h002b
`define ADDR_LINE31_VOLT    16'h002c
`define ADDR_PHASE1_CURR    16'h002d
`define ADDR_PHASE2_CURR    16'h002e
`define ADDR_PHASE3_CURR    16'h002f
`define ADDR_RUN_STATE      16'h0030
`define ADDR_ALARM_LO       16'h0031
`define ADDR_CHARGE_REGIME  16'h0032
`define ADDR_RATED_OUT_V    16'h0033
`define ADDR_RATED_OUT_I    16'h0034
`define ADDR_RATED_INPUT    16'h0035
`define ADDR_MAIN_FW        16'h0036
`define ADDR_AUX_FW         16'h0037
`define ADDR_RELAY_ONE      16'h0038
`define ADDR_RELAY_FOUR     16'h003b
`define ADDR_ALARM_HI       16'h003c

`define HI_FLOAT_BIT        0
`define HI_EQUALIZE_BIT     1
`define HI_BOOST_BIT        2
`define HI_BOOST_EXP_BIT    3
`define HI_ESTOP_BIT        4
`define HI_PARALLEL_BIT     5
`define HI_PREALARM_BIT     6
`define HI_PULSE12_BIT      7
`define HI_TEST_FAIL_BIT    8
`define HI_BAD_SEQ_BIT      9
`define RATED_PHASE_BIT     15

`define WORD_ZERO           16'h0000
`define RUN_ONE             16'h0001
`define REGIME_MAX          3'h4
`define RELAY_COUNT         4

`endif

//--- hdl/rectifier_pkg.sv
package rectifier_pkg;

  typedef logic [15:0] word_t;

  // Charging regime codes as reported to the master
  typedef enum logic [2:0] {
    regime_auto,
    regime_float,
    regime_equalize,
    regime_boost,
    regime_test
  } regime_e;

endpackage

//--- hdl/rectifier_status_register_map.sv
`timescale 1ns/1ps
`include "rectifier_consts.svh"

module rectifier_status_register_map #(
  parameter logic [15:0] rated_out_volts    = 16'h0030,
  parameter logic [15:0] rated_out_amps     = 16'h0014,
  parameter logic [14:0] rated_in_volts     = 15'h00e6,
  parameter logic        three_phase_unit   = 1'b1,
  parameter logic        twelve_pulse_unit  = 1'b0,
  // Firmware words: arbitrary values
  parameter logic [15:0] main_fw_version    = 16'h0001,
  parameter logic [15:0] aux_fw_version     = 16'h0001
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        rd_en,
  input  wire logic [15:0] rd_addr,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  output logic             rd_hit,
  input  wire logic        snap_hold,
  input  wire logic        running,
  input  wire logic [15:0] primary_alarm_cond,
  input  wire logic [2:0]  charge_regime_in,
  input  wire logic        boost_expired,
  input  wire logic        emergency_stop,
  input  wire logic        parallel_fault,
  input  wire logic        temp_prealarm,
  input  wire logic        pulse12_failure,
  input  wire logic        battery_test_failed,
  input  wire logic        bad_phase_sequence,
  input  wire logic [3:0]  relay_energised,
  input  wire logic [15:0] phase_one_volt_in,
  input  wire logic [15:0] phase_two_volt_in,
  input  wire logic [15:0] phase_three_volt_in,
  input  wire logic [15:0] battery_volt_in,
  input  wire logic [15:0] battery_curr_in,
  input  wire logic [15:0] battery_temp_in,
  input  wire logic [15:0] line_freq_in,
  input  wire logic [15:0] line_one_two_volt_in,
  input  wire logic [15:0] line_two_three_volt_in,
  input  wire logic [15:0] line_three_one_volt_in,
  input  wire logic [15:0] phase_one_curr_in,
  input  wire logic [15:0] phase_two_curr_in,
  input  wire logic [15:0] phase_three_curr_in
);

  // Measurement snapshot, frozen while the master reads a block
  rectifier_pkg::word_t    phase1_voltage_r;
  rectifier_pkg::word_t    phase2_voltage_r;
  rectifier_pkg::word_t    phase3_voltage_r;
  rectifier_pkg::word_t    battery_voltage_r;
  rectifier_pkg::word_t    battery_current_r;
  rectifier_pkg::word_t    battery_temperature_r;
  rectifier_pkg::word_t    line_frequency_r;
  rectifier_pkg::word_t    line12_voltage_r;
  rectifier_pkg::word_t    line23_voltage_r;
  rectifier_pkg::word_t    line31_voltage_r;
  rectifier_pkg::word_t    phase1_current_r;
  rectifier_pkg::word_t    phase2_current_r;
  rectifier_pkg::word_t    phase3_current_r;
  rectifier_pkg::regime_e  charge_regime_r;
  rectifier_pkg::word_t    run_state_word;
  rectifier_pkg::word_t    primary_alarm_flags;
  rectifier_pkg::word_t    secondary_alarm_flags;
  rectifier_pkg::word_t    battery_charging_regime;
  rectifier_pkg::word_t    rated_input_word;
  rectifier_pkg::word_t    relay_word [`RELAY_COUNT];
  rectifier_pkg::word_t    rd_data_nxt;
  logic                    rd_hit_nxt;
  logic [2:0]              regime_flags;

  // Float, equalize and boost flags follow the regime in force
  function automatic logic [2:0] regime_to_flags(
    input rectifier_pkg::regime_e r
  );
    logic [2:0] f;
    f = 3'h0;
    unique case (r)
      rectifier_pkg::regime_float:    f = 3'h1;
      rectifier_pkg::regime_equalize: f = 3'h2;
      rectifier_pkg::regime_boost:    f = 3'h4;
      rectifier_pkg::regime_auto,
      rectifier_pkg::regime_test:     f = 3'h0;
      default:                        f = 3'h0;
    endcase
    return f;
  endfunction

  // Snapshot of analogue readings, held off while snap_hold is high
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      phase1_voltage_r      <= `WORD_ZERO;
      phase2_voltage_r      <= `WORD_ZERO;
      phase3_voltage_r      <= `WORD_ZERO;
      battery_voltage_r     <= `WORD_ZERO;
      battery_current_r     <= `WORD_ZERO;
      battery_temperature_r <= `WORD_ZERO;
      line_frequency_r      <= `WORD_ZERO;
      line12_voltage_r      <= `WORD_ZERO;
      line23_voltage_r      <= `WORD_ZERO;
      line31_voltage_r      <= `WORD_ZERO;
      phase1_current_r      <= `WORD_ZERO;
      phase2_current_r      <= `WORD_ZERO;
      phase3_current_r      <= `WORD_ZERO;
    end
    else if (!snap_hold)
    begin
      phase1_voltage_r      <= phase_one_volt_in;
      phase2_voltage_r      <= phase_two_volt_in;
      phase3_voltage_r      <= phase_three_volt_in;
      battery_voltage_r     <= battery_volt_in;
      battery_current_r     <= battery_curr_in;
      battery_temperature_r <= battery_temp_in;
      line_frequency_r      <= line_freq_in;
      line12_voltage_r      <= line_one_two_volt_in;
      line23_voltage_r      <= line_two_three_volt_in;
      line31_voltage_r      <= line_three_one_volt_in;
      phase1_current_r      <= phase_one_curr_in;
      phase2_current_r      <= phase_two_curr_in;
      phase3_current_r      <= phase_three_curr_in;
    end
  end

  // Regime register; an out-of-range code keeps the last good regime
  always_ff @(posedge clk)
  begin
    if (!resetn)
      charge_regime_r <= rectifier_pkg::regime_auto;
    else if (charge_regime_in <= `REGIME_MAX)
      charge_regime_r <= rectifier_pkg::regime_e'(charge_regime_in);
  end

  assign regime_flags = regime_to_flags(charge_regime_r);

  // Status words built from the live conditions, the regime register and the rating parameters
  always_comb
  begin
    run_state_word = running ? `RUN_ONE : `WORD_ZERO;
    primary_alarm_flags = primary_alarm_cond;
    battery_charging_regime = {13'h0000, charge_regime_r};
    rated_input_word = {three_phase_unit, rated_in_volts};
    secondary_alarm_flags = `WORD_ZERO;
    secondary_alarm_flags[`HI_FLOAT_BIT]     = regime_flags[0];
    secondary_alarm_flags[`HI_EQUALIZE_BIT]  = regime_flags[1];
    secondary_alarm_flags[`HI_BOOST_BIT]     = regime_flags[2];
    secondary_alarm_flags[`HI_BOOST_EXP_BIT] = boost_expired;
    secondary_alarm_flags[`HI_ESTOP_BIT]     = emergency_stop;
    secondary_alarm_flags[`HI_PARALLEL_BIT]  = parallel_fault;
    secondary_alarm_flags[`HI_PREALARM_BIT]  = temp_prealarm;
    secondary_alarm_flags[`HI_PULSE12_BIT]   = pulse12_failure;
    secondary_alarm_flags[`HI_TEST_FAIL_BIT] = battery_test_failed;
    // Phase sequence is only meaningful on twelve-pulse units
    secondary_alarm_flags[`HI_BAD_SEQ_BIT] =
      bad_phase_sequence & twelve_pulse_unit;
  end

  // One word per relay, 1 while energised
  genvar gi;
  generate
    for (gi = 0; gi < `RELAY_COUNT; gi++)
    begin : g_relay
      assign relay_word[gi] = {15'h0000, relay_energised[gi]};
    end
  endgenerate

  // Address decode; anything not listed reads zero and misses
  always_comb
  begin
    rd_data_nxt = `WORD_ZERO;
    rd_hit_nxt  = 1'b1;
    unique case (rd_addr)
      `ADDR_PHASE1_VOLT:   rd_data_nxt = phase1_voltage_r;
      `ADDR_PHASE2_VOLT:   rd_data_nxt = phase2_voltage_r;
      `ADDR_PHASE3_VOLT:   rd_data_nxt = phase3_voltage_r;
      `ADDR_BATT_VOLT:     rd_data_nxt = battery_voltage_r;
      `ADDR_BATT_CURR:     rd_data_nxt = battery_current_r;
      `ADDR_BATT_TEMP:     rd_data_nxt = battery_temperature_r;
      `ADDR_LINE_FREQ:     rd_data_nxt = line_frequency_r;
      `ADDR_LINE12_VOLT:   rd_data_nxt = line12_voltage_r;
      `ADDR_LINE23_VOLT:   rd_data_nxt = line23_voltage_r;
      `ADDR_LINE31_VOLT:   rd_data_nxt = line31_voltage_r;
      `ADDR_PHASE1_CURR:   rd_data_nxt = phase1_current_r;
      `ADDR_PHASE2_CURR:   rd_data_nxt = phase2_current_r;
      `ADDR_PHASE3_CURR:   rd_data_nxt = phase3_current_r;
      `ADDR_RUN_STATE:     rd_data_nxt = run_state_word;
      `ADDR_ALARM_LO:      rd_data_nxt = primary_alarm_flags;
      `ADDR_CHARGE_REGIME: rd_data_nxt = battery_charging_regime;
      `ADDR_RATED_OUT_V:   rd_data_nxt = rated_out_volts;
      `ADDR_RATED_OUT_I:   rd_data_nxt = rated_out_amps;
      `ADDR_RATED_INPUT:   rd_data_nxt = rated_input_word;
      `ADDR_MAIN_FW:       rd_data_nxt = main_fw_version;
      `ADDR_AUX_FW:        rd_data_nxt = aux_fw_version;
      `ADDR_ALARM_HI:      rd_data_nxt = secondary_alarm_flags;
      default:
      begin
        if (rd_addr >= `ADDR_RELAY_ONE && rd_addr <= `ADDR_RELAY_FOUR)
          rd_data_nxt = relay_word[rd_addr[1:0]];
        else
          rd_hit_nxt = 1'b0;
      end
    endcase
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rd_data  <= `WORD_ZERO;
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en)
      begin
        rd_data <= rd_data_nxt;
        rd_hit  <= rd_hit_nxt;
      end
    end
  end

endmodule

//--- sim/status_map_props.sv
`timescale 1ns/1ps
module status_map_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        rd_en,
  input wire logic [15:0] rd_addr,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        rd_hit,
  input wire logic        running,
  input wire logic [15:0] primary_alarm_cond,
  input wire logic [3:0]  relay_energised
);
  // Single clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic relay_sel_r;
  // Relay selected by the request address
  always_ff @(posedge clk)
    relay_sel_r <= relay_energised[rd_addr[1:0]];
  // Answer timing and word contents, one cycle after each request
  valid_after_read_a: assert property (rd_en |=> rd_valid)
    else $error("no answer after read");
  valid_single_a: assert property (!rd_en |=> !rd_valid)
    else $error("answer without read");
  data_holds_a: assert property (
    !rd_en |=> $stable(rd_data) && $stable(rd_hit))
    else $error("read word changed while idle");
  run_state_a: assert property (
    rd_en && rd_addr == 16'h0030 |=>
    rd_hit && rd_data == {15'h0000, $past(running)})
    else $error("run state word wrong");
  alarm_lo_a: assert property (
    rd_en && rd_addr == 16'h0031 |=>
    rd_data == $past(primary_alarm_cond))
    else $error("primary alarm word wrong");
  relay_word_a: assert property (
    rd_en && rd_addr[15:2] == 14'h000e |=>
    rd_data == {15'h0000, relay_sel_r})
    else $error("relay word wrong");
  rated_input_a: assert property (
    rd_en && rd_addr == 16'h0035 |=> rd_data == 16'h80e6)
    else $error("rated input word wrong");
  unmapped_zero_a: assert property (
    rd_en && (rd_addr == 16'h0029 || rd_addr > 16'h003c ||
    rd_addr < 16'h0022) |=> rd_data == 16'h0000 && !rd_hit)
    else $error("unassigned address not zero");
endmodule
bind rectifier_status_register_map status_map_props u_props (
  .clk(clk), .resetn(resetn), .rd_en(rd_en), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit),
  .running(running), .primary_alarm_cond(primary_alarm_cond),
  .relay_energised(relay_energised));

//--- sim/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic        clk,
  output logic             rd_en,
  output logic [15:0]      rd_addr
);
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 16'h0000;
  end
  // One word per request, back to back allowed
  task automatic read(input logic [15:0] a);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
  endtask
  // Idle address lines toggle so a stale address never passes
  task automatic release_bus();
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~rd_addr;
  endtask
endmodule

//--- sim/rectifier_status_register_map_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin cmp_count++; \
  if ((s) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end
module rectifier_status_register_map_tb_top;
  logic        clk, resetn, snap_hold, running, rd_en, rd_valid, rd_hit;
  logic [15:0] alarm_lo, rd_addr, rd_data, meas [13], held [13];
  logic [2:0]  regime_in, regime_v;
  logic [6:0]  hi_flags;
  logic [3:0]  relay;
  logic [16:0] exp_q [$];
  int          miscompares, cmp_count;
  bus_master_model u_master (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr));
  rectifier_status_register_map u_dut (.clk(clk), .resetn(resetn),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hit(rd_hit), .snap_hold(snap_hold),
    .running(running), .primary_alarm_cond(alarm_lo),
    .charge_regime_in(regime_in), .boost_expired(hi_flags[0]),
    .emergency_stop(hi_flags[1]), .parallel_fault(hi_flags[2]),
    .temp_prealarm(hi_flags[3]), .pulse12_failure(hi_flags[4]),
    .battery_test_failed(hi_flags[5]), .bad_phase_sequence(hi_flags[6]),
    .relay_energised(relay), .phase_one_volt_in(meas[0]),
    .phase_two_volt_in(meas[1]), .phase_three_volt_in(meas[2]),
    .battery_volt_in(meas[3]), .battery_curr_in(meas[4]),
    .battery_temp_in(meas[5]), .line_freq_in(meas[6]),
    .line_one_two_volt_in(meas[7]), .line_two_three_volt_in(meas[8]),
    .line_three_one_volt_in(meas[9]), .phase_one_curr_in(meas[10]),
    .phase_two_curr_in(meas[11]), .phase_three_curr_in(meas[12]));
  // Expected hit flag and word for one address
  function automatic logic [16:0] expect_of(logic [15:0] a);
    logic [15:0] d;
    d = 16'h0000;
    if (a >= 16'h0022 && a <= 16'h0028)
      d = held[int'(a - 16'h0022)];
    else if (a >= 16'h002a && a <= 16'h002f)
      d = held[int'(a - 16'h0023)];
    else case (a)
      16'h0030: d = {15'h0000, running};
      16'h0031: d = alarm_lo;
      16'h0032: d = {13'h0000, regime_v};
      16'h0033: d = 16'h0030;
      16'h0034: d = 16'h0014;
      16'h0035: d = {1'b1, 15'h00e6};
      16'h0036, 16'h0037: d = 16'h0001;
      16'h0038, 16'h0039, 16'h003a, 16'h003b:
        d = {15'h0000, relay[a[1:0]]};
      16'h003c: d = {7'h00, hi_flags[5:0], regime_v == 3'h3,
        regime_v == 3'h2, regime_v == 3'h1};
      default: d = 16'h0000;
    endcase
    return {a >= 16'h0022 && a <= 16'h003c && a != 16'h0029, d};
  endfunction
  // Note the expected answer, then issue the read
  task automatic rd(input logic [15:0] a);
    exp_q.push_back(expect_of(a));
    u_master.read(a);
  endtask
  // Back-to-back reads of the whole window and its neighbours
  task automatic sweep();
    for (int a = 16'h0020; a <= 16'h003d; a++) rd(16'(a));
    u_master.release_bus();
  endtask
  // New random inputs, then settle before reading
  task automatic scramble(input logic [2:0] r);
    logic [15:0] v;
    @(posedge clk);
    for (int i = 0; i < 13; i++)
    begin
      v = 16'($urandom);
      meas[i] <= v;
      if (!snap_hold) held[i] <= v;
    end
    alarm_lo <= 16'($urandom);
    relay <= 4'($urandom);
    hi_flags <= 7'($urandom);
    running <= 1'($urandom);
    regime_in <= r;
    if (r < 3'h5) regime_v <= r;
    repeat (2) @(posedge clk);
  endtask
  // Counts, then the verdict, then the end of the run
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Each answer is compared with the oldest note
  always @(posedge clk)
    if (rd_valid === 1'b1)
    begin
      `CHK("pending", 1'b1, exp_q.size() > 0)
      `CHK("rd_data", exp_q[0][15:0], rd_data)
      `CHK("rd_hit", exp_q[0][16], rd_hit)
      void'(exp_q.pop_front());
    end
  // Cycle ceiling; running out counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    final_report();
  end
  // Reset, then sweeps, regime codes and snapshot freezing
  initial
  begin
    {resetn, snap_hold, running, alarm_lo, relay, hi_flags} = '0;
    regime_in = 3'h7;
    regime_v = 3'h0;
    foreach (meas[i]) {meas[i], held[i]} = '0;
    void'($urandom(79858));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("reset rd_data", 16'h0000, rd_data)
    `CHK("reset rd_valid", 1'b0, rd_valid)
    `CHK("reset rd_hit", 1'b0, rd_hit)
    sweep();
    repeat (3)
    begin
      scramble(3'($urandom));
      sweep();
    end
    for (int r = 0; r < 8; r++)
    begin
      scramble(3'(r));
      rd(16'h0032);
      rd(16'h003c);
      u_master.release_bus();
    end
    @(posedge clk) snap_hold <= 1'b1;
    scramble(regime_v);
    sweep();
    @(posedge clk) snap_hold <= 1'b0;
    scramble(regime_v);
    sweep();
    repeat (4) @(posedge clk);
    `CHK("all answered", 0, exp_q.size())
    final_report();
  end
endmodule
